// ---- src/kefr_top.sv ----
// key event flag register for keys 4, 3 and 2, cleared on host read
//
// Overview of operation
// - flag register at 02h; bits 7..2 are release/press of keys 4, 3, 2.
// - press flag sets only after key held down past its press settle time.
// - release flag sets only after key stays up past its release settle time.
// - flags the host saw in a read of 02h clear automatically once it completes that read.
// - all flags clear whenever the detect enable bit is zero.
// - accessory removal forces enable to zero and so clears all flags.
// - a key's press flag setting clears that key's release flag.
// - flags read 0 after reset or clear, 1 after their event.
// - detection and flag updates carry on while older flags stay unread.
`timescale 1ns/1ns
module kefr_top
    import kefr_pkg::*;
#(
    parameter int REREAD_CYCLES = KEFR_REREAD_CYCLES
)(
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    // key detector levels and settings
    input  wire logic [KEFR_NUM_KEYS-1:0] key_down,
    input  wire logic                     button_detect_enable,
    input  wire logic                     removal_event,
    input  wire logic [KEFR_SETTLE_W-1:0] button_down_settle_time,
    input  wire logic [KEFR_SETTLE_W-1:0] button_up_settle_time,
    // host register read port
    input  wire logic                     rd_req,
    input  wire logic [7:0]               rd_addr,
    input  wire logic                     rd_done,
    output logic      [7:0]               rd_data,
    output logic      [7:0]               key_event_flags
);
    import kefr_pkg::*;

    kefr_evt_if evt ();

    logic [7:0] read_snap;
    logic [7:0] next_flags;
    logic [7:0] set_mask;
    logic [7:0] rel_kill;
    logic       enabled;

    // bit position of a key's press flag
    function automatic int press_pos(input int k);
        press_pos = KEFR_PRESS_BASE + 2 * k;
    endfunction

    kefr_settle kefr_settle_i (
        .clock                   (clock),
        .rst_n                   (rst_n),
        .key_down                (key_down),
        .button_detect_enable    (enabled),
        .button_down_settle_time (button_down_settle_time),
        .button_up_settle_time   (button_up_settle_time),
        .evt                     (evt)
    );

    // removal acts like the enable bit going low
    assign enabled = button_detect_enable && !removal_event;

    // event masks into register bit positions
    always_comb begin
        set_mask = '0;
        rel_kill = '0;
        for (int k = 0; k < KEFR_NUM_KEYS; k++) begin
            set_mask[press_pos(k)]                   = evt.press[k];
            set_mask[press_pos(k) + KEFR_REL_OFFSET] = evt.release_ev[k];
            rel_kill[press_pos(k) + KEFR_REL_OFFSET] = evt.press[k];
        end
    end

    // next flag value: read clear first, new events win over it
    always_comb begin
        next_flags = key_event_flags;
        if (rd_done) begin
            next_flags = next_flags & ~read_snap;
        end
        next_flags = (next_flags & ~rel_kill) | set_mask;
        if (!enabled) begin
            next_flags = KEFR_FLAGS_RESET;
        end
    end

    // flag register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            key_event_flags <= KEFR_FLAGS_RESET;
        end else begin
            key_event_flags <= next_flags;
        end
    end

    // read data and the snapshot of what the host saw
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data   <= KEFR_UNMAPPED_DATA;
            read_snap <= '0;
        end else if (rd_req) begin
            if (rd_addr == KEFR_ADDR_FLAGS) begin
                rd_data   <= key_event_flags;
                read_snap <= key_event_flags;
            end else begin
                rd_data   <= KEFR_UNMAPPED_DATA;
                read_snap <= '0;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_read_value;
        rd_req && rd_addr == KEFR_ADDR_FLAGS |=> rd_data == $past(key_event_flags);
    endproperty
    a_read_value: assert property (p_read_value) else $error("read data wrong");

    property p_read_clear;
        rd_done && enabled && set_mask == '0 |=> (key_event_flags & $past(read_snap)) == '0;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");

    property p_disable_clear;
        !button_detect_enable |=> key_event_flags == KEFR_FLAGS_RESET;
    endproperty
    a_disable_clear: assert property (p_disable_clear) else $error("flags kept while disabled");

    property p_removal_clear;
        removal_event |=> key_event_flags == KEFR_FLAGS_RESET ##1 $past(evt.press) == '0;
    endproperty
    a_removal_clear: assert property (p_removal_clear) else $error("removal did not clear");

    property p_press_kills_release;
        enabled && rel_kill != '0 |=> (key_event_flags & $past(rel_kill) & ~$past(set_mask)) == '0;
    endproperty
    a_press_kills_release: assert property (p_press_kills_release) else $error("release kept");

    property p_set_has_cause;
        (key_event_flags & ~$past(key_event_flags)) != '0 |-> $past(set_mask) != '0;
    endproperty
    a_set_has_cause: assert property (p_set_has_cause) else $error("flag set without event");

    property p_event_lands;
        enabled && set_mask != '0 |=> (key_event_flags & $past(set_mask)) == $past(set_mask);
    endproperty
    a_event_lands: assert property (p_event_lands) else $error("event lost");

    property p_event_beats_read;
        rd_done && enabled && set_mask != '0 |=> (key_event_flags & $past(set_mask)) != '0;
    endproperty
    a_event_beats_read: assert property (p_event_beats_read) else $error("read clear ate event");

    c_press:   cover property (enabled && evt.press != '0);
    c_release: cover property (enabled && evt.release_ev != '0);
    c_read:    cover property (rd_done && read_snap != '0);
    c_removal: cover property (removal_event && key_event_flags != '0);
endmodule

// ---- src/kefr_pkg.sv ----
// constants for the key event flag register block
package kefr_pkg;
    localparam int         KEFR_NUM_KEYS      = 3;               // keys 4, 3 and 2
    localparam int         KEFR_SETTLE_W      = 16;              // settle time width, clock cycles
    localparam logic [7:0] KEFR_ADDR_FLAGS    = 8'h02;           // key event flag register
    localparam logic [7:0] KEFR_FLAGS_RESET   = 8'h00;
    localparam logic [7:0] KEFR_UNMAPPED_DATA = 8'h00;           // answer to any other address
    localparam int         KEFR_PRESS_BASE    = 2;               // key 2 press bit, next key two above
    localparam int         KEFR_REL_OFFSET    = 1;               // release bit sits above press bit
    localparam int         KEFR_CLOCK_KHZ     = 250_000;
    localparam int         KEFR_REREAD_US     = 200;             // least host gap between reads
    localparam int         KEFR_REREAD_CYCLES = KEFR_REREAD_US * KEFR_CLOCK_KHZ / 1000;
endpackage

// ---- src/kefr_evt_if.sv ----
// settled key events passed from the settle timers to the flag register
`timescale 1ns/1ns
interface kefr_evt_if;
    import kefr_pkg::*;
    logic [KEFR_NUM_KEYS-1:0] press;      // one-cycle pulse per key
    logic [KEFR_NUM_KEYS-1:0] release_ev; // one-cycle pulse per key
    modport src (output press, output release_ev);
    modport dst (input press, input release_ev);
endinterface

// ---- src/kefr_settle.sv ----
// per-key settle timers turning key levels into press and release pulses
`timescale 1ns/1ns
module kefr_settle
    import kefr_pkg::*;
(
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    // key levels and settings
    input  wire logic [KEFR_NUM_KEYS-1:0] key_down,
    input  wire logic                     button_detect_enable,
    input  wire logic [KEFR_SETTLE_W-1:0] button_down_settle_time,
    input  wire logic [KEFR_SETTLE_W-1:0] button_up_settle_time,
    // settled events
    kefr_evt_if.src                       evt
);
    logic [KEFR_NUM_KEYS-1:0] settled;
    logic [KEFR_SETTLE_W-1:0] cnt [KEFR_NUM_KEYS];

    // limit for the level that the key is moving towards
    function automatic logic [KEFR_SETTLE_W-1:0] settle_limit(input logic lvl);
        settle_limit = lvl ? button_down_settle_time : button_up_settle_time;
    endfunction

    // counts cycles the key differs from its settled state, flips past the limit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            settled        <= '0;
            evt.press      <= '0;
            evt.release_ev <= '0;
            for (int k = 0; k < KEFR_NUM_KEYS; k++) begin
                cnt[k] <= '0;
            end
        end else begin
            evt.press      <= '0;
            evt.release_ev <= '0;
            for (int k = 0; k < KEFR_NUM_KEYS; k++) begin
                if (!button_detect_enable || key_down[k] == settled[k]) begin
                    cnt[k] <= '0;
                    if (!button_detect_enable) begin
                        settled[k] <= 1'b0;
                    end
                end else if (cnt[k] >= settle_limit(key_down[k])) begin
                    settled[k]        <= key_down[k];
                    cnt[k]            <= '0;
                    evt.press[k]      <= key_down[k];
                    evt.release_ev[k] <= !key_down[k];
                end else begin
                    cnt[k] <= KEFR_SETTLE_W'(cnt[k] + 1'b1);
                end
            end
        end
    end

    // checks on the settle timers
    for (genvar g = 0; g < KEFR_NUM_KEYS; g++) begin : g_chk
        property p_press_settled;
            @(posedge clock) disable iff (!rst_n)
            evt.press[g] |-> $past(key_down[g]) && $past(cnt[g]) == $past(button_down_settle_time);
        endproperty
        a_press_settled: assert property (p_press_settled) else $error("press pulse before settle");

        property p_release_settled;
            @(posedge clock) disable iff (!rst_n)
            evt.release_ev[g] |-> !$past(key_down[g]) && $past(cnt[g]) == $past(button_up_settle_time);
        endproperty
        a_release_settled: assert property (p_release_settled) else $error("release pulse early");
    end
endmodule

// ---- tb/kefr_host.sv ----
// host model that reads the flag register and keeps the reread gap
`timescale 1ns/1ns
module kefr_host #(
    parameter int GAP = 10
)(
    // clock
    input  wire logic       clock,
    // register read port
    input  wire logic [7:0] rd_data,
    output logic            rd_req,
    output logic [7:0]      rd_addr,
    output logic            rd_done
);
    // idle host at time zero
    initial begin
        rd_req = 1'b0;
        rd_addr = 8'h5a;
        rd_done = 1'b0;
    end
    // one read: request, take answer, complete, then wait out the gap
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        rd_req = 1'b1;
        rd_addr = a;
        @(negedge clock);
        rd_req = 1'b0;
        rd_addr = ~a;               // stale address is not left showing
        d = rd_data;
        rd_done = 1'b1;
        @(negedge clock);
        rd_done = 1'b0;
        repeat (GAP) @(negedge clock);
    endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the key event flag register
`timescale 1ns/1ns
module tb_top;
    import kefr_pkg::*;
    localparam int L = 3;
    logic                     clock = 1'b0;
    logic                     rst_n = 1'b0;
    logic [KEFR_NUM_KEYS-1:0] key_down = '0;
    logic                     button_detect_enable = 1'b1;
    logic                     removal_event = 1'b0;
    logic [KEFR_SETTLE_W-1:0] settle_t = 16'(L);
    logic                     rd_req;
    logic                     rd_done;
    logic [7:0]               rd_addr;
    logic [7:0]               rd_data;
    logic [7:0]               flags;
    logic [7:0]               got;
    int                       bad_count = 0;
    int                       tests_run = 0;

    kefr_top #(.REREAD_CYCLES(10)) kefr_top_i (.clock(clock), .rst_n(rst_n), .key_down(key_down),
        .button_detect_enable(button_detect_enable), .removal_event(removal_event),
        .button_down_settle_time(settle_t), .button_up_settle_time(settle_t), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_done(rd_done), .rd_data(rd_data), .key_event_flags(flags));
    kefr_host #(.GAP(10)) kefr_host_i (.clock(clock), .rd_data(rd_data), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_done(rd_done));

    // free running clock, 4 ns period
    initial begin
        forever #2 clock = ~clock;
    end
    // compare and count
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            $display("MISMATCH at %0t: %s got %h expected %h", $time, m, g, e);
            bad_count++;
        end
    endtask
    task automatic wcy(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic summarize;
        $display("tests run %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // reset values and an unmapped read
    task automatic t_reset;
        chk(flags, KEFR_FLAGS_RESET, "reset flags");
        kefr_host_i.read(8'h03, got);
        chk(got, KEFR_UNMAPPED_DATA, "unmapped read");
        $display("test reset done");
    endtask
    // short glitch ignored, then all three keys pressed
    task automatic t_press;
        key_down = 3'h7;
        wcy(L);
        key_down = 3'h0;
        wcy(L + 3);
        chk(flags, 8'h00, "glitch ignored");
        key_down = 3'h7;
        wcy(L + 1);
        chk(flags, 8'h00, "press too early");
        wcy(2);
        chk(flags, 8'h54, "press bits 6 4 2");
        $display("test press done");
    endtask
    // release adds to unread flags, press of key 4 drops its release
    task automatic t_release;
        key_down = 3'h0;
        wcy(L + 1);
        chk(flags, 8'h54, "release too early");
        wcy(2);
        chk(flags, 8'hfc, "release bits while unread");
        key_down = 3'h4;
        wcy(L + 3);
        chk(flags, 8'h7c, "press clears own release");
        $display("test release done");
    endtask
    // unmapped read clears nothing, flag read clears all
    task automatic t_read;
        kefr_host_i.read(8'h0c, got);
        chk(flags, 8'h7c, "unmapped read keeps flags");
        kefr_host_i.read(KEFR_ADDR_FLAGS, got);
        chk(got, 8'h7c, "flag read data");
        chk(flags, 8'h00, "cleared after read");
        $display("test read done");
    endtask
    // enable low and removal both clear the flags, a press meeting a read clear survives
    task automatic t_enable;
        chk(flags, 8'h00, "key held, no new edge");
        button_detect_enable = 1'b0;
        wcy(2);
        chk(flags, 8'h00, "enable low clears");
        button_detect_enable = 1'b1;
        wcy(L + 3);
        chk(flags, 8'h40, "press after re-enable");
        button_detect_enable = 1'b0;
        wcy(1);
        chk(flags, 8'h00, "enable low clears set flag");
        button_detect_enable = 1'b1;
        wcy(L + 3);
        chk(flags, 8'h40, "press again after re-enable");
        removal_event = 1'b1;
        wcy(1);
        removal_event = 1'b0;
        chk(flags, 8'h00, "removal clears");
        // key 4 still down: its press lands on the edge that sees rd_done
        wcy(2);
        kefr_host_i.read(KEFR_ADDR_FLAGS, got);
        chk(got, 8'h00, "read after removal");
        chk(flags, 8'h40, "press kept over read clear");
        $display("test enable done");
    endtask
    // main sequence
    initial begin
        wcy(8);
        rst_n = 1'b1;
        wcy(1);
        t_reset();
        t_press();
        t_release();
        t_read();
        t_enable();
        summarize();
    end
    // watchdog against a hang
    initial begin
        #20000;
        bad_count++;
        summarize();
    end
endmodule
